// *** irqp_ctrl.sv ***
`timescale 1ns/10ps
// enable, flag and priority registers with request sequencing to the core
module irqp_ctrl
  import irqp_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [DAT_W-1:0]    wb_dat_i,
  output logic      [DAT_W-1:0]    wb_dat_o,
  output logic                     wb_ack_o,
  // peripheral request levels, bit per source index
  input  wire logic [NUM_SRC-1:0]  periph_req_i,
  // set strobes for flags held here
  input  wire logic                t2_reload_set_i,
  input  wire logic                t2_ovf_set_i,
  input  wire logic                conv_set_i,
  input  wire logic                key_set_i,
  input  wire logic                key_cond_i,
  input  wire logic                t2cc_set_i,
  input  wire logic                cmp_set_i,
  // enables owned by other units
  input  wire logic                eeprom_irq_en_i,
  input  wire logic                wdt_irq_en_i,
  // core side
  input  wire logic                core_ack_i,
  input  wire logic                core_reti_i,
  output logic                     irq_o,
  output logic      [SRC_W-1:0]    irq_src_o,
  output logic      [LVL_W-1:0]    irq_lvl_o
);

  // registers
  logic [REG_W-1:0]   ie0_r;        // enable 0
  logic [REG_W-1:0]   ie1_r;        // enable 1
  logic [REG_W-1:0]   ipl0_r;       // priority low 0
  logic [REG_W-1:0]   iph0_r;       // priority high 0
  logic [REG_W-1:0]   ipl1_r;       // priority low 1
  logic [REG_W-1:0]   iph1_r;       // priority high 1
  logic [REG_W-1:0]   flag_r;       // request flags
  logic [REG_W-1:0]   rd_nxt;       // read mux
  logic               ack_r;        // bus answer
  logic [DAT_W-1:0]   rdat_r;       // read data holding
  logic               wr_go;        // write commit strobe
  // request path
  logic [NUM_SRC-1:0] req;          // raw source levels
  logic [NUM_SRC-1:0] en;           // per-source enables
  logic [NUM_SRC-1:0] hi;           // high priority bits
  logic [NUM_SRC-1:0] lo;           // low priority bits
  logic [NUM_SRC-1:0] pend;         // qualified requests
  logic [NUM_SRC-1:0] pend_r;       // polled copy
  logic               win_vld;
  logic [SRC_W-1:0]   win_src;
  logic [LVL_W-1:0]   win_lvl;
  logic               accept;       // winner may interrupt now
  irqp_state_t        state_r;
  logic               irq_r;
  logic [SRC_W-1:0]   src_r;
  logic [LVL_W-1:0]   lvl_r;
  logic [3:0]         act_r;        // in-service mask, bit per level
  logic               taken;        // core took the request
  logic [REG_W-1:0]   set_v;        // flag set strobes
  logic [REG_W-1:0]   hclr_v;       // flag hardware clears

  // highest level currently in service
  function automatic logic [LVL_W-1:0] top_lvl(input logic [3:0] act);
    top_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        top_lvl = LVL_W'(l);
      end
    end
  endfunction : top_lvl

  // ---------------- wishbone slave ----------------

  // commit writes on the edge where the master sees ack
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  // one-cycle ack, dropped the cycle after; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  // read mux; reserved flag bits read zero
  always_comb begin
    rd_nxt = '0;
    if (irqp_hit(wb_adr_i, IE0_IDX)) begin
      rd_nxt = ie0_r;
    end else if (irqp_hit(wb_adr_i, IE1_IDX)) begin
      rd_nxt = ie1_r;
    end else if (irqp_hit(wb_adr_i, IPL0_IDX)) begin
      rd_nxt = ipl0_r;
    end else if (irqp_hit(wb_adr_i, IPH0_IDX)) begin
      rd_nxt = iph0_r;
    end else if (irqp_hit(wb_adr_i, IPL1_IDX)) begin
      rd_nxt = ipl1_r;
    end else if (irqp_hit(wb_adr_i, IPH1_IDX)) begin
      rd_nxt = iph1_r;
    end else if (irqp_hit(wb_adr_i, FLAG_IDX)) begin
      rd_nxt = flag_r & FLAG_MASK;
    end
  end

  // capture read data with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      rdat_r <= {{(DAT_W-REG_W){1'b0}}, rd_nxt};
    end
  end

  // enable and priority registers, plain read/write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ie0_r  <= EN_RST;
      ie1_r  <= EN_RST;
      ipl0_r <= PRIO_RST;
      iph0_r <= PRIO_RST;
      ipl1_r <= PRIO_RST;
      iph1_r <= PRIO_RST;
    end else if (wr_go) begin
      if (irqp_hit(wb_adr_i, IE0_IDX))  ie0_r  <= wb_dat_i[REG_W-1:0];
      if (irqp_hit(wb_adr_i, IE1_IDX))  ie1_r  <= wb_dat_i[REG_W-1:0];
      if (irqp_hit(wb_adr_i, IPL0_IDX)) ipl0_r <= wb_dat_i[REG_W-1:0];
      if (irqp_hit(wb_adr_i, IPH0_IDX)) iph0_r <= wb_dat_i[REG_W-1:0];
      if (irqp_hit(wb_adr_i, IPL1_IDX)) ipl1_r <= wb_dat_i[REG_W-1:0];
      if (irqp_hit(wb_adr_i, IPH1_IDX)) iph1_r <= wb_dat_i[REG_W-1:0];
    end
  end

  // ---------------- request flags ----------------

  // set strobes per flag position
  always_comb begin
    set_v           = '0;
    set_v[FLG_T2R]  = t2_reload_set_i;
    set_v[FLG_TF2]  = t2_ovf_set_i;
    set_v[FLG_CONV] = conv_set_i;
    set_v[FLG_KEY]  = key_set_i;
    set_v[FLG_T2CC] = t2cc_set_i;
    set_v[FLG_CMP]  = cmp_set_i;
  end

  // hardware clears; timer2 flags have none
  always_comb begin
    hclr_v           = '0;
    hclr_v[FLG_CONV] = taken && (src_r == SRC_CONV);
    hclr_v[FLG_T2CC] = taken && (src_r == SRC_T2CC);
    hclr_v[FLG_CMP]  = taken && (src_r == SRC_CMP);
    hclr_v[FLG_KEY]  = !key_cond_i;
  end

  // a set in the clearing cycle wins over software and hardware clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= FLAG_RST;
    end else if (wr_go && irqp_hit(wb_adr_i, FLAG_IDX)) begin
      flag_r <= (set_v | wb_dat_i[REG_W-1:0]) & FLAG_MASK;
    end else begin
      flag_r <= (set_v | (flag_r & ~hclr_v)) & FLAG_MASK;
    end
  end

  // ---------------- qualification and arbitration ----------------

  // source map: levels from peripherals, flags held locally
  always_comb begin
    req           = periph_req_i;
    req[SRC_TMR2] = (flag_r[FLG_TF2] && ie0_r[T2_EN_BIT]) ||
                    (flag_r[FLG_T2R] && ie1_r[T2R_EN_BIT]);
    req[SRC_KEY]  = flag_r[FLG_KEY];
    req[SRC_CONV] = flag_r[FLG_CONV];
    req[SRC_T2CC] = flag_r[FLG_T2CC];
    req[SRC_CMP]  = flag_r[FLG_CMP];
  end

  // per-source enable and priority bit gathering, in rank order
  assign en = {wdt_irq_en_i, ie0_r[6], ie1_r[6], ie1_r[2], eeprom_irq_en_i,
               ie1_r[3], ie1_r[5], ie1_r[1], ie1_r[4], ie1_r[0],
               1'b1, ie0_r[4], ie0_r[3], ie0_r[2], ie0_r[1], ie0_r[0]};
  assign lo = {ipl1_r[7], ipl0_r[6], ipl1_r[6], ipl1_r[2], ipl0_r[7],
               ipl1_r[3], ipl1_r[5], ipl1_r[1], ipl1_r[4], ipl1_r[0],
               ipl0_r[5], ipl0_r[4], ipl0_r[3], ipl0_r[2], ipl0_r[1], ipl0_r[0]};
  assign hi = {iph1_r[7], iph0_r[6], iph1_r[6], iph1_r[2], iph0_r[7],
               iph1_r[3], iph1_r[5], iph1_r[1], iph1_r[4], iph1_r[0],
               iph0_r[5], iph0_r[4], iph0_r[3], iph0_r[2], iph0_r[1], iph0_r[0]};

  // timer2 has two enables, folded into its request above
  assign pend = req & en & {NUM_SRC{ie0_r[GEN_EN_BIT]}};

  // poll stage: flags are looked at one cycle after they settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend;
    end
  end

  irqp_arbiter #(
    .N          (NUM_SRC)
  ) u_arb (
    .pend_i     (pend_r),
    .hi_i       (hi),
    .lo_i       (lo),
    .win_vld_o  (win_vld),
    .win_src_o  (win_src),
    .win_lvl_o  (win_lvl)
  );

  // strictly higher than anything in service
  assign accept = win_vld && (act_r == 4'h0 || win_lvl > top_lvl(act_r));
  assign taken  = (state_r == ST_REQ) && core_ack_i;

  // ---------------- core handshake ----------------

  // request sequencer; the done cycle lets acked flags clear first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      irq_r   <= 1'b0;
      src_r   <= '0;
      lvl_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_REQ;
            irq_r   <= 1'b1;
            src_r   <= win_src;
            lvl_r   <= win_lvl;
          end
        end
        ST_REQ: begin
          if (core_ack_i) begin
            state_r <= ST_DONE;
            irq_r   <= 1'b0;
          end else if (!accept) begin
            // request withdrawn or disabled before the core took it
            state_r <= ST_IDLE;
            irq_r   <= 1'b0;
          end else begin
            src_r   <= win_src;
            lvl_r   <= win_lvl;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
          irq_r   <= 1'b0;
        end
      endcase
    end
  end

  // in-service levels; return clears the highest one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_r <= 4'h0;
    end else begin
      if (core_reti_i && act_r != 4'h0) begin
        act_r[top_lvl(act_r)] <= 1'b0;
      end
      if (taken) begin
        act_r[lvl_r] <= 1'b1;
      end
    end
  end

  // outputs straight from flops
  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = rdat_r;
  assign irq_o     = irq_r;
  assign irq_src_o = src_r;
  assign irq_lvl_o = lvl_r;

  // ---------------- checks ----------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence gen_off_s;
    !ie0_r[GEN_EN_BIT] [*3];
  endsequence

  global_gate_a: assert property (gen_off_s |-> !irq_r)
    else $error("irq raised while global enable clear");
  src_gate0_a: assert property (pend[SRC_SER0] == (periph_req_i[SRC_SER0] && ie0_r[4] && ie0_r[GEN_EN_BIT]))
    else $error("serial0 qualification wrong");
  src_gate1_a: assert property (pend[SRC_SPI] == (periph_req_i[SRC_SPI] && ie1_r[1] && ie0_r[GEN_EN_BIT]))
    else $error("spi qualification wrong");
  off_silent_a: assert property (!ie0_r[0] |-> !pend[SRC_EXT0])
    else $error("disabled source pending");
  t2_sticky_a: assert property (flag_r[FLG_T2R] && !(wr_go && irqp_hit(wb_adr_i, FLAG_IDX)) |=> flag_r[FLG_T2R])
    else $error("reload flag lost without software");
  conv_ackclr_a: assert property (taken && src_r == SRC_CONV && !conv_set_i && !wr_go |=> !flag_r[FLG_CONV])
    else $error("converter flag not cleared on ack");
  key_clr_a: assert property (!key_cond_i && !key_set_i && !wr_go |=> !flag_r[FLG_KEY])
    else $error("keypad flag survived condition loss");
  preempt_lvl_a: assert property (state_r == ST_REQ && act_r != 4'h0 |-> irq_lvl_o > top_lvl(act_r))
    else $error("request not above in-service level");
  resp_delay_a: assert property ($rose(irq_r) |-> $past(pend, POLL_CYC) != '0)
    else $error("irq raised too soon after flag");
  ee_gate_a: assert property (!eeprom_irq_en_i |-> !pend[SRC_EE])
    else $error("eeprom source pending while disabled");
  bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : irqp_ctrl

// *** irqp_pkg.sv ***
package irqp_pkg;

  // bus geometry
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IE0_IDX   = 8'ha8;
  localparam logic [7:0] IPL0_IDX  = 8'ha9;
  localparam logic [7:0] IPH0_IDX  = 8'haa;
  localparam logic [7:0] IE1_IDX   = 8'hb8;
  localparam logic [7:0] IPL1_IDX  = 8'hb9;
  localparam logic [7:0] IPH1_IDX  = 8'hba;
  localparam logic [7:0] FLAG_IDX  = 8'hc0;

  // reset values
  localparam logic [7:0] EN_RST    = 8'h00;
  localparam logic [7:0] PRIO_RST  = 8'h00;
  localparam logic [7:0] FLAG_RST  = 8'h00;

  // field positions
  localparam int GEN_EN_BIT   = 7;      // global_irq_enable in enable 0
  localparam int T2R_EN_BIT   = 7;      // timer2_reload_irq_enable in enable 1
  localparam int T2_EN_BIT    = 5;      // timer2_irq_enable in enable 0
  localparam int FLG_T2R      = 7;      // timer2_reload_flag
  localparam int FLG_TF2      = 6;      // timer2_overflow_flag
  localparam int FLG_CONV     = 5;      // converter_flag
  localparam int FLG_KEY      = 4;      // keypad_flag
  localparam int FLG_T2CC     = 3;      // timer2_capcomp_flag
  localparam int FLG_CMP      = 2;      // comparator_flag
  localparam logic [7:0] FLAG_MASK = 8'hfc;  // low two bits read zero

  // sources in fixed arbitration order, index 0 ranks first
  localparam int NUM_SRC = 16;
  localparam int SRC_W   = 4;
  localparam int LVL_W   = 2;
  localparam logic [3:0] SRC_EXT0  = 4'h0;
  localparam logic [3:0] SRC_TMR0  = 4'h1;
  localparam logic [3:0] SRC_EXT1  = 4'h2;
  localparam logic [3:0] SRC_TMR1  = 4'h3;
  localparam logic [3:0] SRC_SER0  = 4'h4;
  localparam logic [3:0] SRC_TMR2  = 4'h5;
  localparam logic [3:0] SRC_I2C   = 4'h6;
  localparam logic [3:0] SRC_KEY   = 4'h7;
  localparam logic [3:0] SRC_SPI   = 4'h8;
  localparam logic [3:0] SRC_CONV  = 4'h9;
  localparam logic [3:0] SRC_T2CC  = 4'ha;
  localparam logic [3:0] SRC_EE    = 4'hb;
  localparam logic [3:0] SRC_CMP   = 4'hc;
  localparam logic [3:0] SRC_LPD   = 4'hd;
  localparam logic [3:0] SRC_SER1  = 4'he;
  localparam logic [3:0] SRC_WDT   = 4'hf;

  // pipeline stages on this side before the core sees irq_o
  localparam int RESP_MIN_CYC = 4;
  localparam int POLL_CYC     = 2;

  // request handshake towards the core
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_DONE = 2'b11
  } irqp_state_t;

  // word address hits a register index
  function automatic logic irqp_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    irqp_hit = (adr[ADR_W-1:2] == idx);
  endfunction : irqp_hit

endpackage : irqp_pkg

// *** irqp_arbiter.sv ***
`timescale 1ns/10ps
// picks the highest level pending source; equal levels go to lowest index
module irqp_arbiter
  import irqp_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  // pending sources and their priority bits
  input  wire logic [N-1:0]     pend_i,
  input  wire logic [N-1:0]     hi_i,
  input  wire logic [N-1:0]     lo_i,
  // winner
  output logic                  win_vld_o,
  output logic [SRC_W-1:0]      win_src_o,
  output logic [LVL_W-1:0]      win_lvl_o
);

  // index width is fixed by the core's source numbering
  if (N != NUM_SRC) begin : g_chk
    $error("irqp_arbiter: N must equal NUM_SRC");
  end

  // scan from lowest rank upward so a better-ranked tie overwrites
  always_comb begin
    win_vld_o = 1'b0;
    win_src_o = '0;
    win_lvl_o = '0;
    for (int s = N - 1; s >= 0; s--) begin
      if (pend_i[s] && (!win_vld_o || {hi_i[s], lo_i[s]} >= win_lvl_o)) begin
        win_vld_o = 1'b1;
        win_src_o = SRC_W'(s);
        win_lvl_o = {hi_i[s], lo_i[s]};
      end
    end
  end

endmodule : irqp_arbiter

// *** irqp_core_model.sv ***
`timescale 1ns/10ps
// processor core stand-in: takes the shown request promptly or after a stall
module irqp_core_model
  import irqp_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // request from the controller
  input  wire logic             irq_i,
  input  wire logic [SRC_W-1:0] src_i,
  input  wire logic [LVL_W-1:0] lvl_i,
  // bench controls
  input  wire logic             slow_i,
  input  wire logic             reti_req_i,
  // handshake to the controller
  output logic                  core_ack_o,
  output logic                  core_reti_o,
  // record of each accepted request
  output logic                  taken_o,
  output logic [SRC_W-1:0]      taken_src_o,
  output logic [LVL_W-1:0]      taken_lvl_o
);
  logic [1:0] stall_r;  // cycles irq has stood unanswered

  // ack counts only if irq still stands at the edge that samples it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_ack_o <= 1'h0;
      stall_r    <= 2'h0;
      taken_o    <= 1'h0;
    end else begin
      taken_o     <= core_ack_o & irq_i;
      taken_src_o <= src_i;
      taken_lvl_o <= lvl_i;
      if (core_ack_o || !irq_i) begin  // one-cycle ack, restart stall
        core_ack_o <= 1'h0;
        stall_r    <= 2'h0;
      end else if (!slow_i || stall_r == 2'h3) begin
        core_ack_o <= 1'h1;
      end else begin  // slow core lets the request wait
        stall_r <= stall_r + 2'h1;
      end
    end
  end

  // end of service routine, one pulse per bench request
  always_ff @(posedge clk_i) begin
    if (rst_i) core_reti_o <= 1'h0;
    else core_reti_o <= reti_req_i;
  end
endmodule : irqp_core_model

// *** irqp_ctrl_test.sv ***
`timescale 1ns/10ps
// self-checking bench for the interrupt register set
module irqp_ctrl_test
  import irqp_pkg::*;
;
  logic               clk_i = 1'h0;   // 25 MHz
  logic               rst_i = 1'h1;   // sync, active high
  logic               wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0, wb_ack_o;
  logic [ADR_W-1:0]   wb_adr = '0;
  logic [3:0]         wb_sel = 4'h0;
  logic [DAT_W-1:0]   wb_dat = '0, wb_dat_o;
  logic [NUM_SRC-1:0] periph = '0;    // peripheral request levels
  logic [5:0]         set_p = 6'h00;  // t2r,t2o,conv,key,t2cc,cmp strobes
  logic               key_cond = 1'h0, ee_en = 1'h0, wdt_en = 1'h0;
  logic               core_ack, core_reti, irq, slow = 1'h0, reti_req = 1'h0, taken;
  logic [SRC_W-1:0]   irq_src, tk_src;
  logic [LVL_W-1:0]   irq_lvl, tk_lvl;
  logic [7:0]         rd_q[$], irq_q[$];  // expected reads and takes
  logic [7:0]         pr[4];              // low0, high0, low1, high1 images
  logic [31:0]        rng = 32'h0000005c;
  int                 miscompares = 0, checks_done = 0;
  // per source: enable/priority group in bit 3, bit position below
  localparam logic [3:0] MAP [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hc,
                                      4'h9, 4'hd, 4'hb, 4'h7, 4'ha, 4'he, 4'h6, 4'hf};
  localparam logic [7:0] RIDX [7] = '{IE0_IDX, IPL0_IDX, IPH0_IDX, IPL1_IDX, IPH1_IDX,
                                      IE1_IDX, FLAG_IDX};

  always #20 clk_i = ~clk_i;

  irqp_ctrl i_irqp_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .periph_req_i(periph), .t2_reload_set_i(set_p[0]),
    .t2_ovf_set_i(set_p[1]), .conv_set_i(set_p[2]), .key_set_i(set_p[3]),
    .key_cond_i(key_cond), .t2cc_set_i(set_p[4]), .cmp_set_i(set_p[5]),
    .eeprom_irq_en_i(ee_en), .wdt_irq_en_i(wdt_en), .core_ack_i(core_ack),
    .core_reti_i(core_reti), .irq_o(irq), .irq_src_o(irq_src), .irq_lvl_o(irq_lvl));

  irqp_core_model i_irqp_core_model (
    .clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .src_i(irq_src), .lvl_i(irq_lvl),
    .slow_i(slow), .reti_req_i(reti_req), .core_ack_o(core_ack), .core_reti_o(core_reti),
    .taken_o(taken), .taken_src_o(tk_src), .taken_lvl_o(tk_lvl));

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd

  // level a source should be shown at, from the priority images
  function automatic logic [1:0] lvl(input int s);
    return {pr[2*MAP[s][3]+1][MAP[s][2:0]], pr[2*MAP[s][3]][MAP[s][2:0]]};
  endfunction : lvl

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // classic single cycle; request held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= sel;
    wb_dat <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] want);
    rd_q.push_back(want);
    bus(1'h0, idx, 8'h00, 4'h1);
  endtask : rd

  task automatic wait_take();
    while (irq_q.size() != 0) @(posedge clk_i);
  endtask : wait_take

  // no request may stand at the end of this span
  task automatic quiet();
    repeat (8) @(posedge clk_i);
    chk({7'h00, irq}, 8'h00);
  endtask : quiet

  task automatic pulse_reti();
    @(posedge clk_i);
    reti_req <= 1'h1;
    @(posedge clk_i);
    reti_req <= 1'h0;
  endtask : pulse_reti

  // flag sources get a set strobe, the rest a request level
  task automatic raise(input int s);
    @(posedge clk_i);
    case (s)
      5: set_p <= 6'h03;
      7: set_p <= 6'h08;
      9: set_p <= 6'h04;
      10: set_p <= 6'h10;
      12: set_p <= 6'h20;
      default: periph[s] <= 1'h1;
    endcase
    key_cond <= (s == 7);
    @(posedge clk_i);
    set_p <= 6'h00;
  endtask : raise

  // ie1 written first so no stray window with global on
  task automatic en(input int s, input logic on, input logic ea);
    logic [7:0] b;
    b = on ? 8'h01 << MAP[s][2:0] : 8'h00;
    ee_en  <= on && s == 11;
    wdt_en <= on && s == 15;
    wr(IE1_IDX, MAP[s][3] && s != 15 ? b : 8'h00);
    wr(IE0_IDX, {ea, 7'h00} | (!MAP[s][3] && s != 11 ? b : 8'h00));
  endtask : en

  // a first, b after a retires; pre re-raises a over b's service
  task automatic pair(input int a, input int b, input logic [7:0] lo, input logic [7:0] hi, input logic pre);
    wr(IPL0_IDX, lo);
    wr(IPH0_IDX, hi);
    pr[0] = lo;
    pr[1] = hi;
    wr(IE0_IDX, 8'h80 | (8'h01 << a) | (8'h01 << b));
    irq_q.push_back({2'h0, 4'(a), lvl(a)});
    periph <= (16'h0001 << a) | (16'h0001 << b);
    wait_take();
    quiet();
    periph[a] <= 1'h0;
    irq_q.push_back({2'h0, 4'(b), lvl(b)});
    pulse_reti();
    wait_take();
    if (pre) irq_q.push_back({2'h0, 4'(a), lvl(a)});
    periph[a] <= pre;
    if (pre) wait_take();
    else quiet();
    periph <= '0;
    pulse_reti();
    if (pre) pulse_reti();
    wr(IE0_IDX, 8'h00);
  endtask : pair

  // compare each answer against the oldest note of its kind
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && wb_we === 1'h0) chk(wb_dat_o[7:0], rd_q.pop_front());
    if (taken === 1'h1) chk({2'h0, tk_src, tk_lvl}, irq_q.pop_front());
  end

  initial begin
    logic [7:0] v;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (RIDX[i]) rd(RIDX[i], 8'h00);
    // random images; enables cleared again before flags are touched
    for (int i = 0; i < 7; i++) begin
      v = rnd();
      if (i > 0 && i < 5) pr[i-1] = v;
      wr(RIDX[i], v);
      // keypad flag drops again at once, its condition being absent
      rd(RIDX[i], i == 6 ? v & FLAG_MASK & 8'hef : v);
      if (i == 0 || i == 5) wr(RIDX[i], 8'h00);
    end
    wr(FLAG_IDX, 8'h00);
    wr(8'hc4, 8'hff);
    rd(8'hc4, 8'h00);
    bus(1'h1, IE0_IDX, 8'hff, 4'h0);
    rd(IE0_IDX, 8'h00);
    for (int s = 0; s < NUM_SRC; s++) begin
      slow <= s[0];
      raise(s);
      en(s, 1'h1, 1'h0);
      quiet();
      en(s, 1'h0, 1'h1);
      quiet();
      irq_q.push_back({2'h0, 4'(s), lvl(s)});
      en(s, 1'h1, 1'h1);
      wait_take();
      rd(FLAG_IDX, s == 5 ? 8'hc0 : s == 7 ? 8'h10 : 8'h00);
      periph <= '0;
      key_cond <= 1'h0;
      rd(FLAG_IDX, s == 5 ? 8'hc0 : 8'h00);
      wr(FLAG_IDX, 8'h00);
      en(s, 1'h0, 1'h0);
      pulse_reti();
    end
    // reload flag alone reaches timer2 through enable 1 bit 7
    @(posedge clk_i);
    set_p <= 6'h01;
    @(posedge clk_i);
    set_p <= 6'h00;
    irq_q.push_back({2'h0, 4'h5, lvl(5)});
    wr(IE1_IDX, 8'h80);
    wr(IE0_IDX, 8'h80);
    wait_take();
    rd(FLAG_IDX, 8'h80);
    wr(FLAG_IDX, 8'h00);
    wr(IE0_IDX, 8'h00);
    wr(IE1_IDX, 8'h00);
    pulse_reti();
    pair(3, 1, 8'h02, 8'h08, 1'h1);
    pair(2, 4, 8'h00, 8'h00, 1'h0);
    pair(4, 2, 8'h10, 8'h10, 1'h1);
    repeat (8) @(posedge clk_i);
    chk(8'(rd_q.size() + irq_q.size()), 8'h00);
    conclude();
  end

  // hang guard, well beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    conclude();
  end
endmodule : irqp_ctrl_test
